// ===== pwrsav_ctrl.sv
// Power-saving control: sleep/idle select, throttle, regulator mode
`include "pwrsav_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module pwrsav_ctrl
    import pwrsav_pkg::*;
#(
    parameter int RATIO_W = 3
) (
    input  wire logic                CLK,
    input  wire logic                RSTN,
    input  wire logic                WB_CYC_I,
    input  wire logic                WB_STB_I,
    input  wire logic                WB_WE_I,
    input  wire logic [13:0]         WB_ADR_I,
    input  wire logic [3:0]          WB_SEL_I,
    input  wire logic [31:0]         WB_DAT_I,
    output      logic [31:0]         WB_DAT_O,
    output      logic                WB_ACK_O,
    input  wire pwrsav_core_evt_type CORE_EVT,
    input  wire logic                PERIPH_CYCLE,
    output      logic                SYS_CLK_EN,
    output      logic                CPU_RUN,
    output      logic                CPU_CYCLE_EN,
    output      logic                PERIPH_CLK_EN,
    output      logic                OTHER_CLK_HOLD,
    output      logic                IN_IDLE,
    output      logic                IN_SLEEP,
    output      logic                WATCHDOG_RESET_BLOCK,
    output      logic [1:0]          REG_MODE_ACTIVE
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_s1_q;
    logic rst_n_q;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic                 ack_q;
    logic [31:0]          rdata_q;
    pwrsav_thr_ctrl_type  thr_q;
    pwrsav_thr_ctrl_type  thr_d;
    logic [1:0]           mode_sel_q;
    logic [1:0]           mode_sel_d;
    logic [1:0]           mode_act_q;
    pwrsav_state_type     state_q;
    pwrsav_state_type     state_d;

    wire        req      = WB_CYC_I && WB_STB_I && !ack_q;
    wire [11:0] word_idx = WB_ADR_I[13:2];
    wire        hit_thr  = (word_idx == `PWRSAV_THROTTLE_IDLE_CTRL_IDX);
    wire        hit_reg  = (word_idx == `PWRSAV_REGULATOR_CTRL_IDX);
    wire        wr_lane0 = req && WB_WE_I && WB_SEL_I[0];
    wire        wr_thr   = wr_lane0 && hit_thr;
    wire        wr_reg   = wr_lane0 && hit_reg;
    wire [7:0]  thr_rd   = thr_q & 8'hf7;
    wire [7:0]  reg_rd   = {2'h0, mode_act_q, 2'h0, mode_sel_q};
    wire [7:0]  rd_byte  = hit_thr ? thr_rd :
                           hit_reg ? reg_rd : 8'h00;

    // Ack drops after one cycle even if the master keeps its strobe up
    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    // Read data refreshes every cycle; only valid alongside ack
    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= {24'h0, rd_byte};
        end
    end

    // ------------------------------------------------------------
    // Throttle control register
    // ------------------------------------------------------------
    pwrsav_thr_ctrl_type wr_val;
    assign wr_val = pwrsav_thr_ctrl_type'(WB_DAT_I[7:0] & 8'hf7);

    // Hardware events act after the software write; set beats clear
    wire hw_clr = CORE_EVT.isr_entry && thr_q.thr_clr_entry;
    wire hw_set = CORE_EVT.isr_exit && thr_q.thr_set_exit;

    always_comb begin
        thr_d = thr_q;
        if (wr_thr) begin
            thr_d = wr_val;
        end
        if (hw_clr) begin
            thr_d.thr_active = 1'b0;
        end
        if (hw_set) begin
            thr_d.thr_active = 1'b1;
        end
    end

    assign mode_sel_d = wr_reg ? WB_DAT_I[1:0] : mode_sel_q;

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            thr_q <= pwrsav_thr_ctrl_type'(`PWRSAV_THR_CTRL_RESET);
        end else begin
            thr_q <= thr_d;
        end
    end

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_sel_q <= `PWRSAV_REG_MODE_RESET;
        end else begin
            mode_sel_q <= mode_sel_d;
        end
    end

    // ------------------------------------------------------------
    // Regulator status
    // ------------------------------------------------------------
    // Regulator follows selection in Sleep only; status lags one cycle
    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_act_q <= `PWRSAV_REG_MODE_RESET;
        end else if (state_q == PM_SLEEP) begin
            mode_act_q <= mode_sel_q;
        end else begin
            mode_act_q <= REG_HIGH_POWER;
        end
    end

    // ------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------
    // Watchdog wake is not an ISR entry, so throttle is untouched
    always_comb begin
        state_d = state_q;
        case (state_q)
            PM_RUN: begin
                if (CORE_EVT.sleep_instr) begin
                    state_d = thr_q.idle_sel ? PM_IDLE : PM_SLEEP;
                end
            end
            PM_IDLE: begin
                if (CORE_EVT.wake_irq || CORE_EVT.wake_watchdog) begin
                    state_d = PM_RUN;
                end
            end
            PM_SLEEP: begin
                if (CORE_EVT.wake_irq || CORE_EVT.wake_watchdog) begin
                    state_d = PM_RUN;
                end
            end
            default: begin
                state_d = PM_RUN;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= PM_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Throttle ratio counter
    // ------------------------------------------------------------
    // Count reloads with 2^(code+1)-1; CPU steps when it reaches zero
    logic [8:0] thr_cnt_q;
    wire  [8:0] reload = 9'((9'h002 << thr_q.ratio) - 9'h001);
    wire        cnt_zero = (thr_cnt_q == 9'h000);
    wire        throttling = thr_q.thr_active && (state_q == PM_RUN);
    wire        cpu_step = PERIPH_CYCLE && (!throttling || cnt_zero);

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            thr_cnt_q <= 9'h000;
        end else if (!throttling) begin
            thr_cnt_q <= 9'h000;
        end else if (PERIPH_CYCLE) begin
            thr_cnt_q <= cnt_zero ? reload : 9'(thr_cnt_q - 9'h001);
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    // Decoded from next state so gating lines up with the state flops, except CPU_CYCLE_EN, which decodes state_q,
    // REG_MODE_ACTIVE, which copies mode_act_q, and OTHER_CLK_HOLD, which is held at 1
    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            SYS_CLK_EN <= 1'b1;
        end else begin
            SYS_CLK_EN <= (state_d != PM_SLEEP);
        end
    end

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            CPU_RUN <= 1'b1;
        end else begin
            CPU_RUN <= (state_d == PM_RUN);
        end
    end

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            CPU_CYCLE_EN <= 1'b0;
        end else begin
            CPU_CYCLE_EN <= cpu_step && (state_q == PM_RUN);
        end
    end

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            PERIPH_CLK_EN <= 1'b1;
        end else begin
            PERIPH_CLK_EN <= (state_d != PM_SLEEP);
        end
    end

    // Other sources are never gated here; the flop keeps outputs uniform
    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            OTHER_CLK_HOLD <= 1'b1;
        end else begin
            OTHER_CLK_HOLD <= 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            IN_IDLE <= 1'b0;
        end else begin
            IN_IDLE <= (state_d == PM_IDLE);
        end
    end

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            IN_SLEEP <= 1'b0;
        end else begin
            IN_SLEEP <= (state_d == PM_SLEEP);
        end
    end

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            WATCHDOG_RESET_BLOCK <= 1'b0;
        end else begin
            WATCHDOG_RESET_BLOCK <= (state_d == PM_IDLE);
        end
    end

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            REG_MODE_ACTIVE <= `PWRSAV_REG_MODE_RESET;
        end else begin
            REG_MODE_ACTIVE <= mode_act_q;
        end
    end

    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = rdata_q;

endmodule

`default_nettype wire

// ===== pwrsav_defs.svh
// Register offsets, field positions, reset values for power-saving control
`ifndef PWRSAV_DEFS_SVH
`define PWRSAV_DEFS_SVH

`define PWRSAV_REGULATOR_CTRL_IDX      12'h048
`define PWRSAV_THROTTLE_IDLE_CTRL_IDX  12'h4f2
`define PWRSAV_BIT_IDLE_SEL            7
`define PWRSAV_BIT_THR_ACTIVE          6
`define PWRSAV_BIT_THR_CLR_ENTRY       5
`define PWRSAV_BIT_THR_SET_EXIT        4
`define PWRSAV_RATIO_LSB               0
`define PWRSAV_STATUS_LSB              4
`define PWRSAV_MODE_SEL_LSB            0
`define PWRSAV_THR_CTRL_RESET          8'h00
`define PWRSAV_REG_MODE_RESET          2'h2

`endif

// ===== pwrsav_pkg.sv
// Types shared by the power-saving control block
package pwrsav_pkg;

    typedef enum logic [1:0] {
        REG_HIGH_POWER,
        REG_LOW_POWER,
        REG_ULTRA_LOW_POWER,
        REG_LOW_POWER_EXT
    } pwrsav_reg_mode_type;

    typedef enum logic [1:0] {
        PM_RUN,
        PM_IDLE,
        PM_SLEEP
    } pwrsav_state_type;

    typedef struct packed {
        logic       idle_sel;
        logic       thr_active;
        logic       thr_clr_entry;
        logic       thr_set_exit;
        logic       rsvd;
        logic [2:0] ratio;
    } pwrsav_thr_ctrl_type;

    typedef struct packed {
        logic sleep_instr;
        logic isr_entry;
        logic isr_exit;
        logic wake_irq;
        logic wake_watchdog;
    } pwrsav_core_evt_type;

endpackage

// ===== pwrsav_chk.sv
// Port checker for the power-saving control block
`timescale 1ns/1ns
`default_nettype none
module pwrsav_chk
    import pwrsav_pkg::*;
(
    input wire logic                CLK,
    input wire logic                RSTN,
    input wire logic                WB_CYC_I,
    input wire logic                WB_STB_I,
    input wire logic                WB_ACK_O,
    input wire pwrsav_core_evt_type CORE_EVT,
    input wire logic                SYS_CLK_EN,
    input wire logic                CPU_RUN,
    input wire logic                PERIPH_CLK_EN,
    input wire logic                OTHER_CLK_HOLD,
    input wire logic                IN_IDLE,
    input wire logic                IN_SLEEP,
    input wire logic                WATCHDOG_RESET_BLOCK
);
    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    sequence s_take;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence s_wake;
        CORE_EVT.wake_irq || CORE_EVT.wake_watchdog;
    endsequence
    a_ack_one: assert property (
        s_take |=> WB_ACK_O ##1 !WB_ACK_O) else $error("ack timing");
    a_idle_clk: assert property (
        IN_IDLE |-> SYS_CLK_EN && PERIPH_CLK_EN) else $error("idle clk");
    a_sleep_gate: assert property (
        IN_SLEEP |-> !SYS_CLK_EN && !PERIPH_CLK_EN) else $error("sleep clk");
    a_other_clk: assert property (
        OTHER_CLK_HOLD) else $error("other clocks gated");
    a_sleep_entry: assert property (
        CPU_RUN && CORE_EVT.sleep_instr |=> IN_IDLE != IN_SLEEP)
        else $error("no power-save entry");
    a_state_cause: assert property (
        $rose(IN_SLEEP) |-> $past(CORE_EVT.sleep_instr))
        else $error("sleep without instruction");
    a_idle_halt: assert property (
        IN_IDLE |-> !CPU_RUN) else $error("cpu runs in idle");
    a_idle_wake: assert property (
        IN_IDLE ##0 s_wake |=> !IN_IDLE && CPU_RUN) else $error("idle wake");
    a_sleep_wake: assert property (
        IN_SLEEP && CORE_EVT.wake_irq |=> !IN_SLEEP) else $error("sleep wake");
    a_wdt_block: assert property (
        IN_IDLE |-> WATCHDOG_RESET_BLOCK) else $error("watchdog not blocked");
endmodule
bind pwrsav_ctrl pwrsav_chk u_chk (.CLK, .RSTN, .WB_CYC_I, .WB_STB_I,
    .WB_ACK_O, .CORE_EVT, .SYS_CLK_EN, .CPU_RUN, .PERIPH_CLK_EN,
    .OTHER_CLK_HOLD, .IN_IDLE, .IN_SLEEP, .WATCHDOG_RESET_BLOCK);
`default_nettype wire

// ===== pwrsav_ctrl_tb.sv
// Self-checking bench for the power-saving control block
`timescale 1ns/1ns
`default_nettype none
module pwrsav_ctrl_tb;
    import pwrsav_pkg::*;
    // ------------------------------------------------
    // Signals and design
    // ------------------------------------------------
    localparam logic [13:0] A_THR = 14'h13c8;
    localparam logic [13:0] A_REG = 14'h0120;
    localparam logic [7:0]  ISR_W [4] = '{8'h60, 8'h40, 8'h10, 8'h00};
    localparam logic [7:0]  ISR_R [4] = '{8'h20, 8'h40, 8'h50, 8'h00};
    logic clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, pc = 0;
    logic [13:0] adr = '0;
    logic [31:0] wdat = '0, rdat;
    pwrsav_core_evt_type evt = '0;
    logic ack, sys_en, cpu_run, cpu_cyc, per_en, oth;
    logic in_idle, in_sleep, wdt_blk;
    logic [1:0] mode;
    logic [31:0] q [$];
    int errors = 0, cmp_count = 0, cyc_n = 0, n;
    pwrsav_ctrl uut (.CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .CORE_EVT(evt),
        .PERIPH_CYCLE(pc), .SYS_CLK_EN(sys_en), .CPU_RUN(cpu_run),
        .CPU_CYCLE_EN(cpu_cyc), .PERIPH_CLK_EN(per_en),
        .OTHER_CLK_HOLD(oth), .IN_IDLE(in_idle), .IN_SLEEP(in_sleep),
        .WATCHDOG_RESET_BLOCK(wdt_blk), .REG_MODE_ACTIVE(mode));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic test_done();
        $display("errors=%0d cmp_count=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Reads note their expected byte; the monitor pops it at ack
    task automatic wb(input logic w, input logic [13:0] a,
                      input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        if (!w) q.push_back(d);
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic ev(input int b);
        @(posedge clk);
        evt <= pwrsav_core_evt_type'(5'h01 << b);
        @(posedge clk);
        evt <= '0;
        @(negedge clk);
    endtask
    // Counter phase is unknown after a write, so settle one period first
    task automatic thr(input logic [2:0] c, input logic on);
        int p;
        p = on ? (2 << c) : 1;
        wb(1'b1, A_THR, {25'h0, on, 3'h0, c});
        pc <= 1'b1;
        repeat (p) @(posedge clk);
        n = 0;
        repeat (4 * p) begin
            @(posedge clk);
            n += (cpu_cyc === 1'b1);
        end
        chk(n, 4);
        pc <= 1'b0;
    endtask
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0)
            chk(rdat, q.pop_front());
    end
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 30000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        forever #10 clk = ~clk;
    end
    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    initial begin
        logic [7:0] v;
        void'($urandom(32'hb3b4c365));
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        wb(1'b0, A_THR, 32'h00);
        wb(1'b0, A_REG, 32'h02);
        repeat (4) begin
            v = 8'($urandom);
            wb(1'b1, A_THR, 32'(v));
            wb(1'b0, A_THR, 32'(v & 8'hf7));
            wb(1'b1, A_REG, 32'(v));
            wb(1'b0, A_REG, 32'(v & 8'h03));
            wb(1'b1, 14'h0040, 32'(v));
            wb(1'b0, 14'h0040, 32'h00);
        end
        wb(1'b1, A_THR, 32'h80);
        ev(4);
        chk({in_idle, cpu_run, sys_en, per_en, wdt_blk}, 5'h17);
        ev(1);
        chk({in_idle, cpu_run}, 2'h1);
        wb(1'b0, A_THR, 32'h80);
        wb(1'b1, A_THR, 32'he0);
        ev(4);
        ev(0);
        chk({in_idle, cpu_run}, 2'h1);
        wb(1'b0, A_THR, 32'he0);
        wb(1'b1, A_THR, 32'h00);
        for (int m = 0; m < 4; m++) begin
            wb(1'b1, A_REG, 32'(m));
            ev(4);
            repeat (2) @(negedge clk);
            chk({in_sleep, sys_en, per_en, oth, mode}, {4'h9, 2'(m)});
            ev(1);
            chk(in_sleep, 1'b0);
            wb(1'b0, A_REG, 32'(m));
        end
        for (int k = 0; k < 4; k++) begin
            wb(1'b1, A_THR, 32'(ISR_W[k]));
            ev(3 - k / 2);
            wb(1'b0, A_THR, 32'(ISR_R[k]));
        end
        for (int c = 0; c < 8; c++)
            thr(3'(c), 1'b1);
        thr(3'h7, 1'b0);
        test_done();
    end
endmodule
`default_nettype wire
